//--- adc_clk_filt_defines.svh
`ifndef ADC_CLK_FILT_DEFINES_SVH
`define ADC_CLK_FILT_DEFINES_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define IDX_CONVERTER_MODE   8'h01
`define IDX_SETUP_CONFIG0    8'h20
`define IDX_FILTER_CONFIG0   8'h28
`define IDX_CLOCK_STATUS     8'h07
`define ADDR_OF(idx)         ({idx, 2'b00})

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CONVERTER_MODE   16'h0000
`define RST_SETUP_CONFIG0    16'h1000
`define RST_FILTER_CONFIG    16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define MODE_REF_EN          15
`define MODE_CONCEAL_SETTLE_WAIT      14
`define MODE_ONE_CYCLE_SETTLING        13
`define MODE_CLKSEL_HI       3
`define MODE_CLKSEL_LO       2
`define MODE_MASK            16'he77c
`define SETUP_MASK           16'h1fb0
`define FILT_MAP_BIT         15
`define FILT_ORDER_HI        6
`define FILT_ORDER_LO        5
`define FILT_ODR_HI          4
`define FILT_ODR_LO          0
`define FILT_REJ_INDEX       5'h0b

// ****************************************************************
// clock and rate figures
// ****************************************************************
`define OSC_HZ               16000000
`define MASTER_CLK_HZ        2000000
`define SINC5_RATE_SPS       31250
`define OSC_DIV              (`OSC_HZ / `MASTER_CLK_HZ)
`define SINC5_DEC            (`MASTER_CLK_HZ / 2 / `SINC5_RATE_SPS)
`define SINC3_SETTLE_PERIODS 3
`define SINGLE_SETTLE_DEC    12

`endif

//--- adc_clk_filt_pkg.sv
package adc_clk_filt_pkg;

  // clock source codes of the select field
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_INT_OUT  = 2'b01,
    SRC_EXTERNAL = 2'b10,
    SRC_CRYSTAL  = 2'b11
  } clock_src_t;

  // filter path codes of the order field
  typedef enum logic [1:0] {
    FILT_SINC5_SINC1 = 2'b00,
    FILT_RESERVED    = 2'b01,
    FILT_REJECTION   = 2'b10,
    FILT_SINC3       = 2'b11
  } filter_kind_t;

endpackage : adc_clk_filt_pkg

//--- adc_clock_and_filter_config.sv
`timescale 1ns/1ps
`include "adc_clk_filt_defines.svh"

// Overview of operation
// - conversion logic timed by 2 MHz master tick
// - clock source chosen by mode bits 3:2
// - reset selects internal oscillator
// - internal 16 MHz oscillator divided by eight
// - crystal 16 MHz divided to 2 MHz
// - external clock pin drives master directly
// - all rates follow actual master clock
// - option drives oscillator out on io pin
// - active setup picks filter register
// - sinc5+sinc1, sinc3, rejection filters offered
// - sinc5 stage at 31.25 kSPS from a 2 MHz master
// - sinc5+sinc1 at 2.6 kSPS settles once
// - sinc3 settles after three periods
// - map bit makes rest direct decimation
// - map rate is modulator over 32 times value
// - modulator runs at half master clock
// - mode register layout at index 0x01
// - setup register layout at index 0x20
module adc_clock_and_filter_config
  import adc_clk_filt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        internal_osc_clk,
  input  wire logic        crystal_input_pin,
  input  wire logic        crystal_clock_io_pin_in,
  output logic             crystal_clock_io_pin_out,
  output logic             crystal_clock_io_pin_oe_n,
  input  wire logic [1:0]  active_setup,
  output logic             modulator_tick,
  output logic             result_valid,
  output logic             result_settled,
  output logic      [15:0] converter_mode,
  output logic      [15:0] setup_config
);

  // ****************************************************************
  // registers and helpers
  // ****************************************************************
  logic [15:0]  converter_mode_control;
  logic [15:0]  setup_config_zero;
  logic [15:0]  filter_config_reg [4];
  logic         wr_pend;
  logic [7:0]   wr_idx;
  logic         osc_s1, osc_s2, osc_s3;
  logic         xtal_s1, xtal_s2, xtal_s3;
  logic         io_s1, io_s2, io_s3;
  logic         osc_rise, xtal_rise, io_rise, div_edge;
  logic [2:0]   div_cnt;
  logic         master_tick, mod_phase, mod_tick_c;
  logic [4:0]   mod_count;
  logic         sinc5_tick;
  logic [15:0]  dec_count, decim;
  logic         result_tick;
  logic [1:0]   settle_cnt, prev_setup;
  logic         restart, settled_now;
  clock_src_t   src;
  filter_kind_t kind;
  logic [15:0]  active_filt;

  // sinc1 decimation, in sinc5 results, per rate index
  function automatic logic [15:0] odr_decim(input logic [4:0] idx);
    case (idx)
      5'h00:   odr_decim = 16'h0001;
      5'h01:   odr_decim = 16'h0002;
      5'h02:   odr_decim = 16'h0003;
      5'h03:   odr_decim = 16'h0006;
      5'h04:   odr_decim = 16'h000c;
      5'h05:   odr_decim = 16'h001f;
      5'h06:   odr_decim = 16'h003e;
      5'h07:   odr_decim = 16'h0052;
      5'h08:   odr_decim = 16'h009c;
      5'h09:   odr_decim = 16'h0138;
      5'h0a:   odr_decim = 16'h020d;
      5'h0b:   odr_decim = 16'h0275;
      5'h0c:   odr_decim = 16'h061a;
      default: odr_decim = 16'h0757;
    endcase
  endfunction : odr_decim

  // register read mux by word index
  function automatic logic [31:0] reg_read(input logic [7:0] idx);
    case (idx)
      `IDX_CONVERTER_MODE: reg_read = {16'h0000, converter_mode_control};
      `IDX_SETUP_CONFIG0:  reg_read = {16'h0000, setup_config_zero};
      `IDX_FILTER_CONFIG0: reg_read = {16'h0000, filter_config_reg[0]};
      8'h29:               reg_read = {16'h0000, filter_config_reg[1]};
      8'h2a:               reg_read = {16'h0000, filter_config_reg[2]};
      8'h2b:               reg_read = {16'h0000, filter_config_reg[3]};
      `IDX_CLOCK_STATUS:   reg_read = {27'h0000000, settle_cnt,
                                       result_settled, src};
      default:             reg_read = 32'h00000000;
    endcase
  endfunction : reg_read

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture and registered read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend <= hwrite && haddr[31:10] == 22'h000000;
        wr_idx  <= haddr[9:2];
        if (!hwrite && haddr[31:10] == 22'h000000) begin
          hrdata <= reg_read(haddr[9:2]);
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // data phase writes; reserved bits held at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_mode_control <= `RST_CONVERTER_MODE;
      setup_config_zero      <= `RST_SETUP_CONFIG0;
      for (int i = 0; i < 4; i++) begin
        filter_config_reg[i] <= `RST_FILTER_CONFIG;
      end
    end else if (wr_pend) begin
      case (wr_idx)
        `IDX_CONVERTER_MODE:
          converter_mode_control <= hwdata[15:0] & `MODE_MASK;
        `IDX_SETUP_CONFIG0:
          setup_config_zero <= hwdata[15:0] & `SETUP_MASK;
        `IDX_FILTER_CONFIG0: filter_config_reg[0] <= hwdata[15:0];
        8'h29:               filter_config_reg[1] <= hwdata[15:0];
        8'h2a:               filter_config_reg[2] <= hwdata[15:0];
        8'h2b:               filter_config_reg[3] <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  assign converter_mode = converter_mode_control;
  assign setup_config   = setup_config_zero;

  // ****************************************************************
  // clock source synchronisers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {osc_s1, osc_s2, osc_s3}    <= 3'h0;
      {xtal_s1, xtal_s2, xtal_s3} <= 3'h0;
      {io_s1, io_s2, io_s3}       <= 3'h0;
    end else begin
      {osc_s1, osc_s2, osc_s3}    <= {internal_osc_clk, osc_s1, osc_s2};
      {xtal_s1, xtal_s2, xtal_s3} <= {crystal_input_pin, xtal_s1, xtal_s2};
      {io_s1, io_s2, io_s3} <= {crystal_clock_io_pin_in, io_s1, io_s2};
    end
  end

  assign osc_rise  = osc_s2 & ~osc_s3;
  assign xtal_rise = xtal_s2 & ~xtal_s3;
  assign io_rise   = io_s2 & ~io_s3;

  // source decode from the select field
  assign src = clock_src_t'(converter_mode_control[`MODE_CLKSEL_HI:
                                                   `MODE_CLKSEL_LO]);

  // oscillator out on the shared pin when selected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crystal_clock_io_pin_out  <= 1'b0;
      crystal_clock_io_pin_oe_n <= 1'b1;
    end else begin
      crystal_clock_io_pin_out  <= (src == SRC_INT_OUT) & osc_s2;
      crystal_clock_io_pin_oe_n <= (src != SRC_INT_OUT);
    end
  end

  // ****************************************************************
  // master and modulator ticks
  // ****************************************************************
  assign div_edge = (src == SRC_CRYSTAL) ? xtal_rise : osc_rise;

  // divide 16 MHz edges to the 2 MHz master tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 3'h0;
    end else if (src != SRC_EXTERNAL && div_edge) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  always_comb begin
    case (src)
      SRC_EXTERNAL: master_tick = io_rise;
      SRC_INTERNAL,
      SRC_INT_OUT,
      SRC_CRYSTAL:  master_tick = div_edge &&
                                  div_cnt == 3'(`OSC_DIV - 1);
      default:      master_tick = 1'b0;
    endcase
  end

  // modulator on every second master tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_phase <= 1'b0;
    end else if (master_tick) begin
      mod_phase <= ~mod_phase;
    end
  end

  assign mod_tick_c = master_tick & mod_phase;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modulator_tick <= 1'b0;
    end else begin
      modulator_tick <= mod_tick_c;
    end
  end

  // ****************************************************************
  // filter configuration and decimation
  // ****************************************************************
  assign active_filt = filter_config_reg[active_setup];
  assign kind = filter_kind_t'(active_filt[`FILT_ORDER_HI:
                                           `FILT_ORDER_LO]);

  // decimation in sinc5 results for the active path
  always_comb begin
    if (active_filt[`FILT_MAP_BIT]) begin
      decim = {1'b0, active_filt[14:0]};
    end else if (kind == FILT_REJECTION) begin
      decim = odr_decim(`FILT_REJ_INDEX);
    end else begin
      decim = odr_decim(active_filt[`FILT_ODR_HI:`FILT_ODR_LO]);
    end
    if (decim == 16'h0000) begin
      decim = 16'h0001;
    end
  end

  // sinc5 stage: one result per 32 modulator ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_count <= 5'h00;
    end else if (mod_tick_c) begin
      mod_count <= mod_count + 5'h01;
    end
  end

  assign sinc5_tick = mod_tick_c &&
                      mod_count == 5'(`SINC5_DEC - 1);

  // output decimation over sinc5 results
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_count <= 16'h0000;
    end else if (restart) begin
      dec_count <= 16'h0000;
    end else if (sinc5_tick) begin
      if (dec_count >= decim - 16'h0001) begin
        dec_count <= 16'h0000;
      end else begin
        dec_count <= dec_count + 16'h0001;
      end
    end
  end

  assign result_tick = sinc5_tick && !restart &&
                       dec_count >= decim - 16'h0001;

  // ****************************************************************
  // settling tracking
  // ****************************************************************
  assign restart = (wr_pend && (wr_idx == `IDX_CONVERTER_MODE ||
                   wr_idx[7:2] == 6'h0a)) || prev_setup != active_setup;

  always_comb begin
    if (kind == FILT_SINC3 || active_filt[`FILT_MAP_BIT]) begin
      settled_now = settle_cnt == 2'(`SINC3_SETTLE_PERIODS - 1);
    end else if (decim >= 16'(`SINGLE_SETTLE_DEC)) begin
      settled_now = 1'b1;
    end else begin
      settled_now = settle_cnt != 2'h0;
    end
  end

  // result count since restart, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 2'h0;
      prev_setup <= 2'h0;
    end else begin
      prev_setup <= active_setup;
      if (restart) begin
        settle_cnt <= 2'h0;
      end else if (result_tick && settle_cnt != 2'h3) begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // result strobe; single-cycle mode hides unsettled data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid   <= 1'b0;
      result_settled <= 1'b0;
    end else begin
      result_valid <= result_tick && (settled_now ||
                      !converter_mode_control[`MODE_ONE_CYCLE_SETTLING]);
      if (restart) begin
        result_settled <= 1'b0;
      end else if (result_tick) begin
        result_settled <= settled_now;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  src_select_a: assert property (@(posedge clk) disable iff (!reset_n)
    master_tick |-> (src == SRC_EXTERNAL ? io_rise : src == SRC_CRYSTAL ?
      xtal_rise : osc_rise)) else $error("tick from wrong source");

  reset_source_a: assert property (@(posedge clk)
    $rose(reset_n) |-> src == SRC_INTERNAL &&
      converter_mode_control == 16'h0000)
    else $error("reset did not select internal oscillator");

  setup_reset_a: assert property (@(posedge clk)
    $rose(reset_n) |-> setup_config_zero == 16'h1000)
    else $error("setup register reset value wrong");

  osc_divide_a: assert property (@(posedge clk) disable iff (!reset_n)
    (src != SRC_EXTERNAL && master_tick) |-> div_cnt == 3'h7 && div_edge)
    else $error("master tick not on eighth edge");

  ext_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    (src == SRC_EXTERNAL) |-> master_tick == io_rise)
    else $error("external clock not passed through");

  clk_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    (src == SRC_INT_OUT) |=> !crystal_clock_io_pin_oe_n &&
      crystal_clock_io_pin_out == $past(osc_s2))
    else $error("oscillator not driven on io pin");

  sequence mod_on_tick_s;
    mod_tick_c ##1 modulator_tick;
  endsequence

  half_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (master_tick && mod_phase) |-> mod_on_tick_s)
    else $error("modulator tick not every second master tick");

  sinc5_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
    sinc5_tick |-> mod_tick_c && mod_count == 5'h1f)
    else $error("sinc5 result not on 32nd modulator tick");

  direct_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    (active_filt[15] && active_filt[14:0] != 15'h0000) |->
      decim == {1'b0, active_filt[14:0]})
    else $error("direct decimation not taken from register");

  sinc3_settle_a: assert property (@(posedge clk) disable iff (!reset_n)
    (result_tick && kind == FILT_SINC3 && !active_filt[15] &&
     !restart) |-> settled_now == (settle_cnt == 2'h2))
    else $error("sinc3 settled before third period");

  sequence hidden_s;
    result_tick && !settled_now ##1 !result_valid;
  endsequence

  single_cycle_a: assert property (@(posedge clk) disable iff (!reset_n)
    (result_tick && !settled_now && converter_mode_control[13])
      |-> hidden_s)
    else $error("unsettled result shown in single-cycle mode");

endmodule : adc_clock_and_filter_config

//--- clock_source_model.sv
`timescale 1ns/1ps
// ****************************************************************
// clock sources seen at the device pins
// ****************************************************************
module clock_source_model (
  input  wire logic ext_run,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      osc_clk,
  output logic      xtal_clk,
  output logic      io_pin
);
  logic ext_clk;

  // oscillator stand-in, slowed so the synchronisers follow it
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #20 osc_clk = ~osc_clk;
  end

  // crystal runs clean from its start, no double edges
  initial begin
    xtal_clk = 1'b0;
    #7;
    forever #25 xtal_clk = ~xtal_clk;
  end

  // external clock runs only while asked for, still otherwise
  initial begin
    ext_clk = 1'b0;
    #4;
    forever #20 ext_clk = ext_run ? ~ext_clk : 1'b0;
  end

  // device owns the shared pin while its enable is low
  assign io_pin = pin_oe_n ? ext_clk : pin_out;
endmodule : clock_source_model

//--- adc_clock_and_filter_config_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end

module adc_clock_and_filter_config_tb_top
  import adc_clk_filt_pkg::*;
;
  // pin periods in clk cycles, set by the clock model
  localparam int OSC_CLKS   = 4;
  localparam int XTAL_CLKS  = 5;
  localparam int EXT_CLKS   = 4;
  localparam int SINC5_CLKS = 32 * 2 * EXT_CLKS;

  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp, ext_run;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans, active_setup;
  logic        osc, xtal, io_in, io_out, io_oe_n, v;
  logic        modulator_tick, result_valid, result_settled;
  logic [15:0] converter_mode, setup_config;
  int          bad_count, samples_checked, c;
  clock_src_t  sel_tab [4] = '{SRC_INTERNAL, SRC_INT_OUT, SRC_CRYSTAL,
                               SRC_EXTERNAL};
  int          gap_tab [4] = '{16 * OSC_CLKS, 16 * OSC_CLKS,
                               16 * XTAL_CLKS, 2 * EXT_CLKS};

  adc_clock_and_filter_config dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_osc_clk(osc), .crystal_input_pin(xtal),
    .crystal_clock_io_pin_in(io_in), .crystal_clock_io_pin_out(io_out),
    .crystal_clock_io_pin_oe_n(io_oe_n), .active_setup(active_setup),
    .modulator_tick(modulator_tick), .result_valid(result_valid),
    .result_settled(result_settled), .converter_mode(converter_mode),
    .setup_config(setup_config));

  clock_source_model src (
    .ext_run(ext_run), .pin_out(io_out), .pin_oe_n(io_oe_n),
    .osc_clk(osc), .xtal_clk(xtal), .io_pin(io_in));

  // ****************************************************************
  // bus and pulse helpers
  // ****************************************************************
  // one single ahb transfer, entered right after a rising edge
  task automatic bus(input logic wr, input logic [31:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50)
      bad_count++;
  endtask : bus

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data, rdata);
  endtask : wr

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0000_0000, rdata);
    `CHK(rdata, exp)
  endtask : rd_chk

  function automatic logic pick(input bit res);
    return res ? result_valid : modulator_tick;
  endfunction : pick

  // cycles until the next pulse of the chosen output
  task automatic wait_pulse(input bit res, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (pick(res) !== 1'b1 && cyc < 9000);
  endtask : wait_pulse

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ****************************************************************
  // clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #600us;
    bad_count++;
    conclude();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {active_setup, ext_run, reset_n} = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // reset contents and access masks
    rd_chk(32'h04, 32'h0000_0000);
    rd_chk(32'h80, 32'h0000_1000);
    rd_chk(32'h1c, 32'h0000_0000);
    wr(32'h04, 32'hffff_ffff);
    rd_chk(32'h04, 32'h0000_e77c);
    `CHK(converter_mode, 16'he77c)
    wr(32'h80, 32'hffff_ffff);
    rd_chk(32'h80, 32'h0000_1fb0);
    `CHK(setup_config, 16'h1fb0)
    // unmapped and out-of-range places
    wr(32'h3fc, 32'h0000_5a5a);
    rd_chk(32'h3fc, 32'h0000_0000);
    wr(32'h404, 32'h0000_0000);
    rd_chk(32'h04, 32'h0000_e77c);
    `CHK(hresp, 1'b0)
    // each clock source and its modulator rate
    for (int i = 0; i < 4; i++) begin
      ext_run <= (sel_tab[i] == SRC_EXTERNAL);
      wr(32'h04, {28'h0, sel_tab[i], 2'b00});
      rd_chk(32'h1c, {30'h0, sel_tab[i]});
      `CHK(io_oe_n, sel_tab[i] != SRC_INT_OUT)
      wait_pulse(1'b0, c);
      wait_pulse(1'b0, c);
      wait_pulse(1'b0, c);
      `CHK(c, gap_tab[i])
      v = io_out;
      repeat (2) @(posedge clk);
      if (sel_tab[i] == SRC_INT_OUT)
        `CHK(io_out, ~v)
    end
    // result rates on the fast external clock
    wr(32'ha0, 32'h0000_0000);
    wr(32'ha4, 32'h0000_0001);
    wait_pulse(1'b1, c);
    wait_pulse(1'b1, c);
    `CHK(c, SINC5_CLKS)
    active_setup <= 2'b01;
    wait_pulse(1'b1, c);
    wait_pulse(1'b1, c);
    `CHK(c, 2 * SINC5_CLKS)
    wr(32'ha4, 32'h0000_8003);
    wait_pulse(1'b1, c);
    wait_pulse(1'b1, c);
    `CHK(c, 3 * SINC5_CLKS)
    // sinc3 settles on the third result
    active_setup <= 2'b00;
    wr(32'ha0, 32'h0000_0060);
    for (int k = 1; k <= 3; k++) begin
      wait_pulse(1'b1, c);
      @(posedge clk);
      `CHK(result_settled, k == 3)
    end
    // sinc5 path settles at once at decimation 12, not at 1
    wr(32'ha0, 32'h0000_0004);
    wait_pulse(1'b1, c);
    @(posedge clk);
    `CHK(result_settled, 1'b1)
    wr(32'ha0, 32'h0000_0000);
    wait_pulse(1'b1, c);
    @(posedge clk);
    `CHK(result_settled, 1'b0)
    // single-cycle settling hides unsettled sinc3 results
    wr(32'ha0, 32'h0000_0060);
    wr(32'h04, 32'h0000_2008);
    wait_pulse(1'b1, c);
    `CHK(c > 3 * SINC5_CLKS - 30 && c < 3 * SINC5_CLKS + 30, 1'b1)
    // reset in mid-run returns to the internal oscillator
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(32'h04, 32'h0000_0000);
    rd_chk(32'h1c, 32'h0000_0000);
    conclude();
  end
endmodule : adc_clock_and_filter_config_tb_top
